// ===== inc/sfpe_defs.vh
// Constants for the serial flash program and erase sequencer.
// Assumes a 50 MHz system clock and a 24-bit byte address.
`ifndef SFPE_DEFS_VH
`define SFPE_DEFS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFPE_OP_PAGE_PROGRAM 8'h02
`define SFPE_OP_SECTOR_ERASE 8'h20
`define SFPE_OP_BLOCK32_ERASE 8'h52
`define SFPE_OP_BLOCK64_ERASE 8'hd8
`define SFPE_OP_WRITE_ENABLE 8'h06

// ----------------------------------------------------------------
// Frame layout in bytes
// ----------------------------------------------------------------
`define SFPE_OPCODE_BYTES 1
`define SFPE_HEADER_BYTES 4
`define SFPE_PROGRAM_MIN_BYTES 5
`define SFPE_PAGE_BYTES 256

// ----------------------------------------------------------------
// Erase kinds on eraseKind
// ----------------------------------------------------------------
`define SFPE_KIND_SECTOR 2'h0
`define SFPE_KIND_BLOCK32 2'h1
`define SFPE_KIND_BLOCK64 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFPE_CLOCK_PERIOD_NS 20
`define SFPE_PROGRAM_CYCLE_TIME_NS 700000
`define SFPE_ERASE_CYCLE_TIME_NS 50000000
`define SFPE_PROGRAM_CYCLES (`SFPE_PROGRAM_CYCLE_TIME_NS / `SFPE_CLOCK_PERIOD_NS)
`define SFPE_ERASE_CYCLES (`SFPE_ERASE_CYCLE_TIME_NS / `SFPE_CLOCK_PERIOD_NS)

`endif

// ===== core/sfpe_flash_seq.v
// Serial flash command decoder and self-timed program/erase sequencer.
// Assumes the SPI pins come from outside the clock domain; memory array
// and protection bits live outside and are reached by plain ports.
//
// Operation
// - Data past page end wraps to start
// - Only final 256 bytes are programmed
// - Unsent page bytes stay unchanged
// - Program needs select rise on byte boundary
// - Program cycle sets busy for program time
// - Write enable latch clears during cycle
// - Protected page program is ignored
// - Erase needs rise right after address
// - Sector erase sets busy for erase time
// - Protected sector erase is not done
// - Block erase sets busy until done
// - Protected block erase is ignored
// - Bits sampled on serial clock rise
// - Commands during busy are rejected harmlessly
`timescale 1ns/1ps
`include "sfpe_defs.vh"

module sfpe_flash_seq #(
    parameter PGM_CYCLES = `SFPE_PROGRAM_CYCLES,
    parameter ERASE_CYCLES = `SFPE_ERASE_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // SPI pins
    input wire spiClk,
    input wire chipSelN,
    input wire serialIn,
    // Protection setting
    input wire [4:0] blockProtect,
    // Status
    output wire writeInProgress,
    output reg writeEnableLatch_q,
    output reg busyReject_q,
    // Memory program port
    output reg memWrite_q,
    output reg [23:0] memAddr_q,
    output reg [7:0] memData_q,
    // Memory erase port
    output reg eraseStart_q,
    output reg [23:0] eraseAddr_q,
    output reg [1:0] eraseKind_q
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_PROG = 3'h2;
    localparam [2:0] ST_ERASE = 3'h4;

    // Protection check on the 64K block index of an address
    function isProtected;
        input [23:0] addr;
        input [4:0] bp;
        reg [4:0] count;
        reg [3:0] blk;
        begin
            count = 5'h0;
            blk = addr[19:16];
            if (bp[2:0] != 3'h0) begin
                count = (bp[2:0] >= 3'h5) ? 5'h10 : (5'h1 << (bp[2:0] - 3'h1));
            end
            if (bp[4]) begin
                isProtected = ({1'b0, blk} < count);
            end else begin
                isProtected = ({1'b0, blk} >= (5'h10 - count));
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [2:0] clkSync_q; // Two sync stages plus edge history
    reg [1:0] csSync_q; // Select synchroniser
    reg [1:0] siSync_q; // Data synchroniser
    reg csPrev_q; // Synced select, one cycle late

    // Sample pins into the clock domain
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clkSync_q <= 3'h0;
            csSync_q <= 2'h3;
            siSync_q <= 2'h0;
            csPrev_q <= 1'b1;
        end else begin
            clkSync_q <= {clkSync_q[1:0], spiClk};
            csSync_q <= {csSync_q[0], chipSelN};
            siSync_q <= {siSync_q[0], serialIn};
            csPrev_q <= csSync_q[1];
        end
    end

    wire sclkRise = clkSync_q[1] & ~clkSync_q[2]; // Serial clock rising
    wire csLow = ~csSync_q[1]; // Frame active
    wire csFall = ~csSync_q[1] & csPrev_q; // Frame start
    wire csRise = csSync_q[1] & ~csPrev_q; // Frame end
    wire siBit = siSync_q[1]; // Sampled data bit

    // ----------------------------------------------------------------
    // Frame capture
    // ----------------------------------------------------------------
    reg [2:0] state_q; // One-hot sequencer state
    reg [6:0] shift_q; // Partial byte
    reg [2:0] bitPos_q; // Bit within byte
    reg [2:0] byteCnt_q; // Whole bytes, saturating
    reg [7:0] opcode_q; // Received opcode
    reg [23:0] addr_q; // Received address
    reg [7:0] dataCnt_q; // Data byte offset, wraps
    reg frameIgnored_q; // Frame began while busy
    reg [7:0] pageBuf [0:255]; // Page buffer
    reg [255:0] pageMask_q; // Bytes sent in this frame
    reg [31:0] cycleCnt_q; // Self-timed cycle counter

    wire busy = ~state_q[0];
    wire [7:0] fullByte = {shift_q, siBit};
    wire byteDone = sclkRise & csLow & ~frameIgnored_q & (bitPos_q == 3'h7);
    wire isProgOp = (opcode_q == `SFPE_OP_PAGE_PROGRAM);
    wire [7:0] bufIdx = addr_q[7:0] + dataCnt_q;

    // Shift bits, bytes, opcode, address and data
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shift_q <= 7'h0;
            bitPos_q <= 3'h0;
            byteCnt_q <= 3'h0;
            opcode_q <= 8'h0;
            addr_q <= 24'h0;
            dataCnt_q <= 8'h0;
            frameIgnored_q <= 1'b0;
            pageMask_q <= 256'h0;
        end else if (csFall) begin
            // New frame; a frame opened while busy is dropped whole
            bitPos_q <= 3'h0;
            byteCnt_q <= 3'h0;
            dataCnt_q <= 8'h0;
            frameIgnored_q <= busy;
            if (!busy) begin
                pageMask_q <= 256'h0;
            end
        end else if (sclkRise && csLow && !frameIgnored_q) begin
            shift_q <= fullByte[6:0];
            bitPos_q <= bitPos_q + 3'h1;
            if (bitPos_q == 3'h7) begin
                if (byteCnt_q != 3'h7) begin
                    byteCnt_q <= byteCnt_q + 3'h1;
                end
                if (byteCnt_q < `SFPE_OPCODE_BYTES) begin
                    opcode_q <= fullByte;
                end else if (byteCnt_q < `SFPE_HEADER_BYTES) begin
                    addr_q <= {addr_q[15:0], fullByte};
                end else if (isProgOp) begin
                    // Later bytes overwrite earlier ones at same slot
                    dataCnt_q <= dataCnt_q + 8'h1;
                    pageMask_q[bufIdx] <= 1'b1;
                end
            end
        end
    end

    // Page buffer write, no reset needed on data storage
    always @(posedge clock) begin
        if (byteDone && byteCnt_q >= `SFPE_HEADER_BYTES && isProgOp) begin
            pageBuf[bufIdx] <= fullByte;
        end
    end

    // ----------------------------------------------------------------
    // Frame end decode
    // ----------------------------------------------------------------
    wire onBoundary = (bitPos_q == 3'h0);
    wire endValid = csRise & ~frameIgnored_q & ~busy;
    wire progOk = isProgOp && onBoundary && byteCnt_q >= `SFPE_PROGRAM_MIN_BYTES;
    wire isEraseOp = (opcode_q == `SFPE_OP_SECTOR_ERASE) ||
                     (opcode_q == `SFPE_OP_BLOCK32_ERASE) ||
                     (opcode_q == `SFPE_OP_BLOCK64_ERASE);
    wire eraseOk = isEraseOp && onBoundary && byteCnt_q == `SFPE_HEADER_BYTES;
    wire wrenOk = (opcode_q == `SFPE_OP_WRITE_ENABLE) && onBoundary &&
                  byteCnt_q == `SFPE_OPCODE_BYTES;
    wire addrProt = isProtected(addr_q, blockProtect);
    wire startProg = endValid & progOk & writeEnableLatch_q & ~addrProt;
    wire startErase = endValid & eraseOk & writeEnableLatch_q & ~addrProt;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    reg [1:0] kind; // Erase kind and alignment
    reg [23:0] alignedAddr;

    always @* begin
        kind = `SFPE_KIND_SECTOR;
        alignedAddr = {addr_q[23:12], 12'h0};
        if (opcode_q == `SFPE_OP_BLOCK32_ERASE) begin
            kind = `SFPE_KIND_BLOCK32;
            alignedAddr = {addr_q[23:15], 15'h0};
        end else if (opcode_q == `SFPE_OP_BLOCK64_ERASE) begin
            kind = `SFPE_KIND_BLOCK64;
            alignedAddr = {addr_q[23:16], 16'h0};
        end
    end

    // Timed program and erase cycles, latch and memory strobes
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cycleCnt_q <= 32'h0;
            writeEnableLatch_q <= 1'b0;
            busyReject_q <= 1'b0;
            memWrite_q <= 1'b0;
            memAddr_q <= 24'h0;
            memData_q <= 8'h0;
            eraseStart_q <= 1'b0;
            eraseAddr_q <= 24'h0;
            eraseKind_q <= 2'h0;
        end else begin
            memWrite_q <= 1'b0;
            eraseStart_q <= 1'b0;
            // Frames ending while busy are dropped and flagged
            busyReject_q <= csRise & (busy | frameIgnored_q);
            case (state_q)
                ST_IDLE: begin
                    cycleCnt_q <= 32'h0;
                    if (startProg) begin
                        state_q <= ST_PROG;
                        writeEnableLatch_q <= 1'b0;
                    end else if (startErase) begin
                        state_q <= ST_ERASE;
                        writeEnableLatch_q <= 1'b0;
                        eraseStart_q <= 1'b1;
                        eraseAddr_q <= alignedAddr;
                        eraseKind_q <= kind;
                    end else if (endValid && wrenOk) begin
                        writeEnableLatch_q <= 1'b1;
                    end
                end
                ST_PROG: begin
                    // First 256 cycles walk the page, writing sent bytes only
                    if (cycleCnt_q < `SFPE_PAGE_BYTES && pageMask_q[cycleCnt_q[7:0]]) begin
                        memWrite_q <= 1'b1;
                        memAddr_q <= {addr_q[23:8], cycleCnt_q[7:0]};
                        memData_q <= pageBuf[cycleCnt_q[7:0]];
                    end
                    cycleCnt_q <= cycleCnt_q + 32'h1;
                    if (cycleCnt_q == PGM_CYCLES - 1) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    cycleCnt_q <= cycleCnt_q + 32'h1;
                    if (cycleCnt_q == ERASE_CYCLES - 1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign writeInProgress = busy;

endmodule

// ===== test/sfpe_flash_seq_assertions.sv
// Port assertions for the flash program and erase sequencer.
// Assumes it is bound onto sfpe_flash_seq with matching cycle counts.
`timescale 1ns/1ps
module sfpe_flash_seq_checker #(
    parameter PGM_CYCLES = 300,
    parameter ERASE_CYCLES = 20
) (
    // Clock, reset, select
    input wire clock,
    input wire rstn,
    input wire chipSelN,
    // Status
    input wire writeInProgress,
    input wire writeEnableLatch_q,
    // Memory ports
    input wire memWrite_q,
    input wire [23:0] memAddr_q,
    input wire eraseStart_q,
    input wire [23:0] eraseAddr_q,
    input wire [1:0] eraseKind_q
);
    // Busy cycles so far
    reg [31:0] wipCnt_q;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) wipCnt_q <= 32'h0;
        else wipCnt_q <= writeInProgress ? wipCnt_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Start of a cycle, select settled high
    sequence busyStart;
        $rose(writeInProgress);
    endsequence
    sequence selSettled;
        chipSelN && $past(chipSelN, 2);
    endsequence
    latch_clear_a: assert property (busyStart |-> !writeEnableLatch_q &&
        $past(writeEnableLatch_q)) else $error("latch not cleared at cycle start");
    start_on_select_a: assert property (busyStart |-> selSettled)
        else $error("cycle started without select high");
    busy_hold_a: assert property (busyStart |=> writeInProgress[*8])
        else $error("busy dropped early");
    busy_length_a: assert property ($fell(writeInProgress) |->
        (wipCnt_q + 2 >= PGM_CYCLES && wipCnt_q <= PGM_CYCLES) ||
        (wipCnt_q + 2 >= ERASE_CYCLES && wipCnt_q <= ERASE_CYCLES))
        else $error("busy length wrong");
    erase_start_a: assert property (eraseStart_q |-> busyStart)
        else $error("erase start outside cycle start");
    erase_align_a: assert property (eraseStart_q |-> eraseAddr_q[11:0] == 12'h0 &&
        (eraseKind_q == 2'h0 || eraseAddr_q[14:0] == 15'h0 && eraseKind_q != 2'h3) &&
        (eraseKind_q != 2'h2 || !eraseAddr_q[15])) else $error("erase base misaligned");
    write_in_busy_a: assert property (memWrite_q |-> writeInProgress &&
        wipCnt_q < PGM_CYCLES) else $error("write outside program cycle");
    page_stay_a: assert property (memWrite_q && $past(memWrite_q) |->
        $stable(memAddr_q[23:8])) else $error("write left the page");
    busy_quiet_a: assert property (writeInProgress && !$rose(writeInProgress) |->
        !eraseStart_q) else $error("erase started while busy");
endmodule
bind sfpe_flash_seq sfpe_flash_seq_checker #(.PGM_CYCLES(PGM_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)) i_chk (.clock(clock), .rstn(rstn), .chipSelN(chipSelN),
    .writeInProgress(writeInProgress), .writeEnableLatch_q(writeEnableLatch_q),
    .memWrite_q(memWrite_q), .memAddr_q(memAddr_q), .eraseStart_q(eraseStart_q),
    .eraseAddr_q(eraseAddr_q), .eraseKind_q(eraseKind_q));

// ===== test/sfpe_spi_host.sv
// Host model: frames queued bytes on the SPI pins, mode 0, MSB first.
// Assumes the bench clock; pins change on its falling edge.
`timescale 1ns/1ps
module sfpe_spi_host (
    // Bench clock
    input wire clock,
    // SPI pins
    output logic spiClk,
    output logic chipSelN,
    output logic serialIn
);
    // Bytes of the next frame
    logic [7:0] txBytes [$];
    // Idle: deselected, link clock still
    initial begin
        spiClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // Half link period, 80 ns
    task automatic halfBit();
        repeat (4) @(negedge clock);
    endtask
    // Shift n bits, data set before each rise
    task automatic shiftBits(input logic [7:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            serialIn = b[7 - k];
            halfBit();
            spiClk = 1'b1;
            halfBit();
            spiClk = 1'b0;
        end
    endtask
    // Whole frame; tail adds stray bits
    task automatic frame(input int tail);
        @(negedge clock);
        chipSelN = 1'b0;
        halfBit();
        while (txBytes.size() > 0) shiftBits(txBytes.pop_front(), 8);
        shiftBits(8'ha5, tail);
        halfBit();
        chipSelN = 1'b1;
        serialIn = ~serialIn;
        repeat (8) @(negedge clock);
    endtask
endmodule

// ===== test/sfpe_flash_seq_test.sv
// Self-checking bench for the flash program and erase sequencer.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`include "sfpe_defs.vh"
module sfpe_flash_seq_test;
    // Clock, reset, protection
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] blockProtect = 5'h0;
    // Design outputs and pins
    wire spiClk, chipSelN, serialIn, writeInProgress, writeEnableLatch_q, busyReject_q;
    wire memWrite_q, eraseStart_q;
    wire [23:0] memAddr_q, eraseAddr_q;
    wire [7:0] memData_q;
    wire [1:0] eraseKind_q;
    // Recorded traffic and tallies
    logic [7:0] pageSeen [0:255];
    logic [15:0] lastPage;
    logic [25:0] lastErase;
    logic [7:0] ops [3] = '{`SFPE_OP_SECTOR_ERASE, `SFPE_OP_BLOCK32_ERASE, `SFPE_OP_BLOCK64_ERASE};
    logic [23:0] bases [3] = '{24'h0af000, 24'h0a8000, 24'h0a0000};
    int nWrites, nErases, nRejects, nErrors, nCompared;
    always #10 clock = ~clock;
    sfpe_spi_host i_sfpe_spi_host (.clock(clock), .spiClk(spiClk), .chipSelN(chipSelN),
        .serialIn(serialIn));
    sfpe_flash_seq #(.PGM_CYCLES(300), .ERASE_CYCLES(20)) i_sfpe_flash_seq (.clock(clock),
        .rstn(rstn), .spiClk(spiClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .blockProtect(blockProtect), .writeInProgress(writeInProgress),
        .writeEnableLatch_q(writeEnableLatch_q), .busyReject_q(busyReject_q),
        .memWrite_q(memWrite_q), .memAddr_q(memAddr_q), .memData_q(memData_q),
        .eraseStart_q(eraseStart_q), .eraseAddr_q(eraseAddr_q), .eraseKind_q(eraseKind_q));
    // Record memory pulses and rejects
    always @(posedge clock) begin
        if (memWrite_q === 1'b1) begin
            pageSeen[memAddr_q[7:0]] = memData_q;
            lastPage = memAddr_q[23:8];
            nWrites++;
        end
        if (eraseStart_q === 1'b1) begin
            lastErase = {eraseKind_q, eraseAddr_q};
            nErases++;
        end
        if (busyReject_q === 1'b1) nRejects++;
    end
    // Data byte k of a program frame
    function automatic logic [7:0] dat(input int k);
        return k[7:0] ^ {k[8], 7'h0};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (nErrors == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Frame opcode, address, n data bytes, stray bits
    task automatic send(input logic [7:0] op, input logic [23:0] a, input int n, input int t);
        if (writeInProgress === 1'b0) begin
            nWrites = 0;
            nErases = 0;
            nRejects = 0;
        end
        i_sfpe_spi_host.txBytes.push_back(op);
        if (op != `SFPE_OP_WRITE_ENABLE) begin
            for (int k = 2; k >= 0; k--) i_sfpe_spi_host.txBytes.push_back(a[8 * k +: 8]);
        end
        for (int k = 0; k < n; k++) i_sfpe_spi_host.txBytes.push_back(dat(k));
        i_sfpe_spi_host.frame(t);
    endtask
    // Bounded wait for idle
    task automatic settle();
        repeat (400) if (writeInProgress !== 1'b0) @(negedge clock);
        check("idle", writeInProgress, 0);
    endtask
    task automatic write_enable_cmd();
        send(`SFPE_OP_WRITE_ENABLE, 0, 0, 0);
        settle();
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        // Wrapped short program
        write_enable_cmd();
        send(`SFPE_OP_PAGE_PROGRAM, 24'h0123f0, 20, 0);
        settle();
        check("writes", nWrites, 20);
        check("page", lastPage, 16'h0123);
        for (int k = 0; k < 20; k++) check("wrap", pageSeen[(240 + k) % 256], dat(k));
        check("latch", writeEnableLatch_q, 0);
        // Overlong program
        write_enable_cmd();
        send(`SFPE_OP_PAGE_PROGRAM, 24'h000500, 258, 0);
        settle();
        check("writes", nWrites, 256);
        for (int k = 0; k < 3; k++) check("last", pageSeen[k], dat(k < 2 ? k + 256 : k));
        // Program ending mid-byte
        write_enable_cmd();
        send(`SFPE_OP_PAGE_PROGRAM, 24'h000600, 2, 3);
        settle();
        check("writes", nWrites, 0);
        // Erase of each size
        for (int k = 0; k < 3; k++) begin
            write_enable_cmd();
            send(ops[k], 24'h0afbcd, 0, 0);
            settle();
            check("erases", nErases, 1);
            check("erase", lastErase, {k[1:0], bases[k]});
        end
        // Erase with extra byte
        write_enable_cmd();
        send(`SFPE_OP_SECTOR_ERASE, 24'h001000, 1, 0);
        settle();
        check("erases", nErases, 0);
        // Top block protected
        blockProtect = 5'h01;
        for (int k = 0; k < 3; k++) begin
            write_enable_cmd();
            send(ops[k], 24'h0f1000, 0, 0);
            settle();
            check("erases", nErases, 0);
        end
        write_enable_cmd();
        send(`SFPE_OP_PAGE_PROGRAM, 24'h0f0000, 4, 0);
        settle();
        check("writes", nWrites, 0);
        // Bottom block protected, top block free again
        blockProtect = 5'h11;
        write_enable_cmd();
        send(`SFPE_OP_SECTOR_ERASE, 24'h00f000, 0, 0);
        settle();
        check("erases", nErases, 0);
        write_enable_cmd();
        send(`SFPE_OP_SECTOR_ERASE, 24'h0f1000, 0, 0);
        settle();
        check("erase", lastErase, {2'h0, 24'h0f1000});
        blockProtect = 5'h00;
        // Frame during a program cycle
        write_enable_cmd();
        send(`SFPE_OP_PAGE_PROGRAM, 24'h000800, 1, 0);
        send(`SFPE_OP_WRITE_ENABLE, 0, 0, 0);
        settle();
        check("writes", nWrites, 1);
        check("rejects", nRejects, 1);
        check("latch", writeEnableLatch_q, 0);
        tally_and_finish();
    end
    // Watchdog
    initial begin
        #1500000;
        nErrors++;
        tally_and_finish();
    end
endmodule
